// *** cld_top.sv ***
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Only fundamental-frequency phase magnitudes are compared.
// - Each phase is compared against every threshold once per 5 ms program-cycle tick.
// - An active comparison releases only at 97 percent of its threshold.
// - One threshold value is shared by all three phases.
// - Pick-up occurs when any of the phases exceeds a threshold.
// - Cold-load arms only with all phases below low threshold.
// - High-current detection needs all phases above the high threshold.
// - Any phase above overcurrent drops the output immediately.
// - Five modes, default on, mode readable back.
// - Side select picks one of two measurement modules, default first.
// - Condition status reports one of five states, default normal.
// - Mode and side do not follow setting group.
// - Thresholds follow active group, switched live without restart.
// - Low current must persist start delay before output activates.
// - Output releases when max inrush timer expires above high threshold.
// - Output holds at least the minimum hold time after start ends.
// - Blocking at pick-up gives blocked indication and no activation.
module cld_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cld_pkg::cld_phases_t side1_fundamental,
  input wire cld_pkg::cld_phases_t side2_fundamental,
  input wire logic block_in,
  output logic cold_load_active,
  output logic cold_load_blocked,
  output cld_pkg::cld_cond_t condition,
  output logic irq
);
  import cld_pkg::*;

  logic [2:0] mode_q;
  logic side_q, grp_q;
  cld_thr_t thr_q [2];
  logic [TMR_W-1:0] start_delay_time_q, max_inrush_time_q, min_hold_time_q;
  logic [2:0] sts_q, mask_q;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic blk_s1_q, blk_q;
  logic [2:0] ev_d;

  // Blocking input comes from outside the clock domain.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      blk_s1_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      blk_s1_q <= block_in;
      blk_q <= blk_s1_q;
    end
  end

  // Write channel: address and data are taken in either order.
  logic wr_go;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[1:0] == 2'b00 && awaddr_q <= A_MASK && awaddr_q != A_STAT
                        && awaddr_q != A_IRQ) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Settings; mode and side are static, thresholds are per setting group.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= M_ON;
      side_q <= 1'b0;
      grp_q <= 1'b0;
      thr_q[0] <= '{low: LOW_DEF, high: HIGH_DEF, over: OVER_DEF};
      thr_q[1] <= '{low: LOW_DEF, high: HIGH_DEF, over: OVER_DEF};
      start_delay_time_q <= START_DELAY_TIME_DEF;
      max_inrush_time_q <= MAX_INRUSH_TIME_DEF;
      min_hold_time_q <= MIN_HOLD_TIME_DEF;
      mask_q <= 3'h0;
    end else if (wr_go) begin
      case (awaddr_q)
        A_MODE: begin
          if (wstrb_q[0] && wdata_q[2:0] <= 3'h4) begin
            mode_q <= wdata_q[MODE_LSB +: 3];
          end
          if (wstrb_q[0]) begin
            side_q <= wdata_q[SIDE_BIT];
          end
          if (wstrb_q[1]) begin
            grp_q <= wdata_q[GRP_BIT];
          end
        end
        A_LOW0: thr_q[0].low <= MAG_W'(merge({16'h0000, thr_q[0].low}, wdata_q, wstrb_q));
        A_HIGH0: thr_q[0].high <= MAG_W'(merge({16'h0000, thr_q[0].high}, wdata_q, wstrb_q));
        A_OVER0: thr_q[0].over <= MAG_W'(merge({16'h0000, thr_q[0].over}, wdata_q, wstrb_q));
        A_LOW1: thr_q[1].low <= MAG_W'(merge({16'h0000, thr_q[1].low}, wdata_q, wstrb_q));
        A_HIGH1: thr_q[1].high <= MAG_W'(merge({16'h0000, thr_q[1].high}, wdata_q, wstrb_q));
        A_OVER1: thr_q[1].over <= MAG_W'(merge({16'h0000, thr_q[1].over}, wdata_q, wstrb_q));
        A_START_DELAY_TIME: start_delay_time_q <= merge(start_delay_time_q, wdata_q, wstrb_q);
        A_MAX_INRUSH_TIME: max_inrush_time_q <= merge(max_inrush_time_q, wdata_q, wstrb_q);
        A_MIN_HOLD_TIME: min_hold_time_q <= merge(min_hold_time_q, wdata_q, wstrb_q);
        A_MASK: mask_q <= wdata_q[2:0];
        default: begin
        end
      endcase
    end
  end

  // Program-cycle tick every 5 ms; all detection steps advance on it.
  logic [31:0] tick_cnt_q;
  logic tick_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 32'(STEP_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(STEP_CYC - 1)) ? 32'h0000_0000 : tick_cnt_q + 32'h1;
    end
  end

  // Comparators with 97 percent hysteresis, common threshold per level.
  cld_phases_t meas;
  cld_thr_t thr;
  assign meas = side_q ? side2_fundamental : side1_fundamental;
  assign thr = thr_q[grp_q];

  logic [2:0] above_low_q, above_high_q, above_over_q;
  logic [MAG_W-1:0] ph [3];
  assign ph[0] = meas.a;
  assign ph[1] = meas.b;
  assign ph[2] = meas.c;

  function automatic logic hyst(input logic act, input logic [MAG_W-1:0] m,
                                input logic [MAG_W-1:0] t);
    logic [MAG_W+7:0] m100, t97;
    m100 = (MAG_W+8)'(m) * (MAG_W+8)'(100);
    t97 = (MAG_W+8)'(t) * (MAG_W+8)'(HYST_PCT);
    return act ? (m100 > t97) : (m > t);
  endfunction

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      above_low_q <= 3'h0;
      above_high_q <= 3'h0;
      above_over_q <= 3'h0;
    end else if (tick_q) begin
      for (int i = 0; i < 3; i++) begin
        above_low_q[i] <= hyst(above_low_q[i], ph[i], thr.low);
        above_high_q[i] <= hyst(above_high_q[i], ph[i], thr.high);
        above_over_q[i] <= hyst(above_over_q[i], ph[i], thr.over);
      end
    end
  end

  logic all_low, all_high, any_over, between;
  assign all_low = (above_low_q == 3'h0);
  assign all_high = &above_high_q;
  assign any_over = |above_over_q;
  assign between = !all_low && !all_high;

  typedef enum logic [2:0] {S_IDLE, S_ARM, S_HOLD, S_INRUSH, S_BLOCKED} cld_state_t;
  cld_state_t st_q;
  logic [TMR_W-1:0] tmr_q;
  logic off_mode, blk_act;
  assign off_mode = (mode_q == M_OFF);
  assign blk_act = blk_q || mode_q == M_BLOCKED || mode_q == M_TESTBLK;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_IDLE;
      tmr_q <= '0;
    end else if (off_mode) begin
      st_q <= S_IDLE;
      tmr_q <= '0;
    end else if (tick_q) begin
      case (st_q)
        S_IDLE: begin
          tmr_q <= '0;
          if (all_low) begin
            st_q <= S_ARM;
          end
        end
        S_ARM: begin
          if (!all_low) begin
            st_q <= S_IDLE;
            tmr_q <= '0;
          end else if (tmr_q >= start_delay_time_q) begin
            st_q <= blk_act ? S_BLOCKED : S_HOLD;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        S_HOLD: begin
          if (any_over || blk_act) begin
            st_q <= S_IDLE;
            tmr_q <= '0;
          end else if (all_high) begin
            st_q <= S_INRUSH;
            tmr_q <= '0;
          end else if (between && tmr_q >= min_hold_time_q) begin
            st_q <= S_IDLE;
            tmr_q <= '0;
          end else if (between) begin
            tmr_q <= tmr_q + 1'b1;
          end else begin
            tmr_q <= '0;
          end
        end
        S_INRUSH: begin
          if (any_over || blk_act) begin
            st_q <= S_IDLE;
            tmr_q <= '0;
          end else if (tmr_q >= max_inrush_time_q) begin
            st_q <= S_IDLE;
            tmr_q <= '0;
          end else if (!all_high) begin
            st_q <= S_HOLD;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        S_BLOCKED: begin
          if (!all_low) begin
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Outputs and condition status.
  cld_cond_t cond_d;
  always_comb begin
    cond_d = C_NORMAL;
    if (off_mode) begin
      cond_d = C_NORMAL;
    end else if (st_q == S_BLOCKED) begin
      cond_d = C_BLOCKED;
    end else if (st_q == S_HOLD || st_q == S_INRUSH) begin
      cond_d = C_ACTIVE;
    end else if (any_over) begin
      cond_d = C_OVER;
    end else if (all_low) begin
      cond_d = C_LOW;
    end
  end

  assign ev_d = {st_q == S_BLOCKED && !cold_load_blocked,
                 (st_q != S_HOLD && st_q != S_INRUSH) && cold_load_active,
                 (st_q == S_HOLD || st_q == S_INRUSH) && !cold_load_active};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cold_load_active <= 1'b0;
      cold_load_blocked <= 1'b0;
      condition <= C_NORMAL;
    end else begin
      // The state falls back to idle one cycle after off mode starts, so gate here too.
      cold_load_active <= (st_q == S_HOLD || st_q == S_INRUSH) && !any_over
                          && !off_mode;
      cold_load_blocked <= (st_q == S_BLOCKED);
      condition <= cond_d;
    end
  end

  // Sticky events; a read of the event register (A_IRQ) clears, a new event wins.
  logic rd_sts;
  assign rd_sts = s_axi_arvalid && s_axi_arready && s_axi_araddr == A_IRQ;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sts_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      sts_q <= (rd_sts ? 3'h0 : sts_q) | ev_d;
      irq <= |(((rd_sts ? 3'h0 : sts_q) | ev_d) & mask_q);
    end
  end

  // Read channel.
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (s_axi_araddr)
      A_MODE: rd_d = {23'h0, grp_q, 3'h0, side_q, 1'b0, mode_q};
      A_LOW0: rd_d = {16'h0, thr_q[0].low};
      A_HIGH0: rd_d = {16'h0, thr_q[0].high};
      A_OVER0: rd_d = {16'h0, thr_q[0].over};
      A_LOW1: rd_d = {16'h0, thr_q[1].low};
      A_HIGH1: rd_d = {16'h0, thr_q[1].high};
      A_OVER1: rd_d = {16'h0, thr_q[1].over};
      A_START_DELAY_TIME: rd_d = start_delay_time_q;
      A_MAX_INRUSH_TIME: rd_d = max_inrush_time_q;
      A_MIN_HOLD_TIME: rd_d = min_hold_time_q;
      A_STAT: rd_d = {22'h0, blk_q, cold_load_blocked, cold_load_active, 4'h0, condition};
      A_IRQ: rd_d = {29'h0, sts_q};
      A_MASK: rd_d = {29'h0, mask_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= A_MASK) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_over_drops: assert property (@(posedge clk_sys) disable iff (!resetn)
    any_over |=> !cold_load_active) else $error("Output stayed up over threshold.");
  a_off_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    off_mode && $past(off_mode) |=> (!cold_load_active && condition == C_NORMAL))
    else $error("Off mode not quiet.");
  a_block_no_act: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q == S_BLOCKED |=> !cold_load_active && cold_load_blocked)
    else $error("Blocked state activated output.");
  sequence s_arm_done;
    st_q == S_ARM && tick_q && all_low && tmr_q >= start_delay_time_q && !blk_act && !off_mode;
  endsequence
  a_arm_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_arm_done |=> st_q == S_HOLD) else $error("Start delay did not activate.");
  a_arm_early: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q == S_ARM && tmr_q < start_delay_time_q |=> st_q != S_HOLD)
    else $error("Activated before start delay.");
  a_max_expire: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q == S_INRUSH && tick_q && tmr_q >= max_inrush_time_q && !off_mode |=> st_q == S_IDLE)
    else $error("Max inrush timer ignored.");
  a_arm_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q == S_ARM && tick_q && !all_low && !off_mode |=> tmr_q == '0)
    else $error("Start timer not cleared.");
  a_cond_active: assert property (@(posedge clk_sys) disable iff (!resetn)
    cold_load_active |-> condition == C_ACTIVE) else $error("Condition mismatch.");
endmodule
`default_nettype wire

// *** cld_pkg.sv ***
package cld_pkg;
  // Magnitudes are in hundredths of nominal current (0.01 x In per LSB).
  localparam int MAG_W = 16;
  localparam int TMR_W = 32;
  localparam logic [MAG_W-1:0] LOW_DEF = 16'h0014;
  localparam logic [MAG_W-1:0] HIGH_DEF = 16'h0078;
  localparam logic [MAG_W-1:0] OVER_DEF = 16'h00c8;
  localparam int HYST_PCT = 97;
  // Timer settings in 5 ms steps.
  localparam int STEP_MS = 5;
  localparam logic [TMR_W-1:0] START_DELAY_TIME_DEF = 32'h0000_07d0;
  localparam logic [TMR_W-1:0] MAX_INRUSH_TIME_DEF = 32'h0000_1770;
  localparam logic [TMR_W-1:0] MIN_HOLD_TIME_DEF = 32'h0000_0008;
  localparam int CLK_HZ = 10000000;
  localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  // AXI4-Lite map.
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_LOW0 = 8'h04;
  localparam logic [7:0] A_HIGH0 = 8'h08;
  localparam logic [7:0] A_OVER0 = 8'h0c;
  localparam logic [7:0] A_LOW1 = 8'h10;
  localparam logic [7:0] A_HIGH1 = 8'h14;
  localparam logic [7:0] A_OVER1 = 8'h18;
  localparam logic [7:0] A_START_DELAY_TIME = 8'h1c;
  localparam logic [7:0] A_MAX_INRUSH_TIME = 8'h20;
  localparam logic [7:0] A_MIN_HOLD_TIME = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_IRQ = 8'h2c;
  localparam logic [7:0] A_MASK = 8'h30;
  localparam int MODE_LSB = 0;
  localparam int SIDE_BIT = 4;
  localparam int GRP_BIT = 8;
  typedef enum logic [2:0] {M_ON, M_BLOCKED, M_TEST, M_TESTBLK, M_OFF} cld_mode_t;
  typedef enum logic [2:0] {C_NORMAL, C_LOW, C_OVER, C_ACTIVE, C_BLOCKED} cld_cond_t;
  typedef struct packed {
    logic [MAG_W-1:0] a;
    logic [MAG_W-1:0] b;
    logic [MAG_W-1:0] c;
  } cld_phases_t;
  typedef struct packed {
    logic [MAG_W-1:0] low;
    logic [MAG_W-1:0] high;
    logic [MAG_W-1:0] over;
  } cld_thr_t;
endpackage

// *** cld_fe_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cld_fe_model (
  input wire logic clk_sys,
  input wire logic cold,
  output cld_pkg::cld_phases_t side1_fundamental,
  output cld_pkg::cld_phases_t side2_fundamental,
  output logic block_in
);
  import cld_pkg::*;
  int seed = 68;

  // Values change every cycle so that no comparator can lean on a stale sample.
  function automatic logic [MAG_W-1:0] rnd(input int lo, input int span);
    int v;
    v = int'($unsigned($random(seed)) % span);
    return MAG_W'(lo + v);
  endfunction

  initial begin
    side1_fundamental = {3{16'h0032}};
    side2_fundamental = {3{16'h0032}};
    block_in = 1'b0;
  end

  // Only fundamental magnitudes are delivered, one per phase, on both sides.
  // In the cold case the selected second side dips low while the first side stays high.
  always @(posedge clk_sys) begin
    if (cold) begin
      side1_fundamental <= {rnd(150, 50), rnd(150, 50), rnd(150, 50)};
      side2_fundamental <= {rnd(0, 30), rnd(0, 30), rnd(0, 30)};
    end else begin
      side1_fundamental <= {rnd(50, 50), rnd(50, 50), rnd(50, 50)};
      side2_fundamental <= {rnd(50, 50), rnd(50, 50), rnd(50, 50)};
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cld_pkg::*;
  typedef struct packed {logic [31:0] d; logic [1:0] r; logic dc;} cld_note_t;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic cold = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, cl_active, cl_blocked, block_in;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  cld_cond_t condition;
  cld_phases_t side1, side2;
  cld_note_t rq[$];
  cld_note_t nt;
  logic [1:0] wq[$];
  int n_errors = 0;
  int checks = 0;

  always #50 clk_sys = ~clk_sys;

  cld_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .side1_fundamental(side1), .side2_fundamental(side2), .block_in(block_in),
    .cold_load_active(cl_active), .cold_load_blocked(cl_blocked), .condition(condition),
    .irq(irq));

  cld_fe_model i_fe (.clk_sys(clk_sys), .cold(cold), .side1_fundamental(side1),
    .side2_fundamental(side2), .block_in(block_in));

  task automatic cmp_bus(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmp_out(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Responses are judged here, against the oldest note left by the driver.
  always @(posedge clk_sys) begin
    if (bvalid === 1'b1 && bready) begin
      if (wq.size() == 0) cmp_bus("bresp unexpected", 32'h0, 32'h1);
      else cmp_bus("bresp", {30'h0, wq.pop_front()}, {30'h0, bresp});
    end
    if (rvalid === 1'b1 && rready) begin
      if (rq.size() == 0) cmp_bus("rdata unexpected", 32'h0, 32'h1);
      else begin
        nt = rq.pop_front();
        cmp_bus("rresp", {30'h0, nt.r}, {30'h0, rresp});
        if (!nt.dc) cmp_bus("rdata", nt.d, rdata);
      end
    end
  end

  // The trailing edge keeps a following call from driving the same signals in one step.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                     input logic dc);
    rq.push_back('{d: d, r: r, dc: dc});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  initial begin
    repeat (101000) @(posedge clk_sys);
    n_errors++;
    $display("Error watchdog expected end seen hang");
    tally_and_finish;
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    axr(A_MODE, 32'h0, 2'b00, 1'b0);
    axr(A_LOW0, 32'h14, 2'b00, 1'b0);
    axr(A_HIGH0, 32'h78, 2'b00, 1'b0);
    axr(A_OVER0, 32'hc8, 2'b00, 1'b0);
    axr(A_START_DELAY_TIME, 32'h7d0, 2'b00, 1'b0);
    axr(A_MAX_INRUSH_TIME, 32'h1770, 2'b00, 1'b0);
    axr(A_MIN_HOLD_TIME, 32'h8, 2'b00, 1'b0);
    // Before the first tick every comparator is clear, so all currents read as low.
    axr(A_STAT, {29'h0, C_LOW}, 2'b00, 1'b0);
    axr(8'h3c, 32'h0, 2'b10, 1'b1);
    axw(A_STAT, 32'h1, 2'b10);
    for (int m = 0; m < 5; m++) begin
      axw(A_MODE, 32'h110 | m, 2'b00);
      axr(A_MODE, 32'h110 | m, 2'b00, 1'b0);
    end
    // An undefined mode code must leave the off mode in place.
    axw(A_MODE, 32'h115, 2'b00);
    axr(A_MODE, 32'h114, 2'b00, 1'b0);
    axw(A_MODE, 32'h110, 2'b00);
    axw(A_LOW1, 32'h1e, 2'b00);
    axr(A_LOW1, 32'h1e, 2'b00, 1'b0);
    axw(A_START_DELAY_TIME, 32'h0, 2'b00);
    axw(A_MASK, 32'h0, 2'b00);
    cold <= 1'b1;
    // Some low-side values sit above the group 0 threshold, so only group 1 keeps all phases low on every tick.
    for (int i = 0; i < 100500 && cl_active !== 1'b1; i++) @(posedge clk_sys);
    cmp_out("cold_load_active", 1'b1, cl_active);
    cmp_out("cold_load_blocked", 1'b0, cl_blocked);
    cmp_bus("condition", {29'h0, C_ACTIVE}, {29'h0, condition});
    cmp_out("irq masked", 1'b0, irq);
    axr(A_STAT, 32'h83, 2'b00, 1'b0);
    axw(A_MASK, 32'h7, 2'b00);
    repeat (2) @(posedge clk_sys);
    cmp_out("irq", 1'b1, irq);
    axr(A_IRQ, 32'h1, 2'b00, 1'b0);
    repeat (2) @(posedge clk_sys);
    cmp_out("irq cleared", 1'b0, irq);
    cmp_out("cold_load_active held", 1'b1, cl_active);
    tally_and_finish;
  end
endmodule
`default_nettype wire
